/* pkg/transfer_controller_pkg.sv */
package transfer_controller_pkg;

  // widths of the shared memory bus, the counter and the source select, and the peripheral count
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int SEL_W = 4;
  localparam int PERIPH_COUNT = 12;

  // register byte offsets on the slave bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_DST = 8'h0c;
  localparam logic [7:0] OFS_RELOAD = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_REPEAT = 1;
  localparam int CTRL_BYTE = 2;
  localparam int CTRL_SRC_FWD = 3;
  localparam int CTRL_DST_FWD = 4;
  localparam int CTRL_REQ = 5;
  localparam int CTRL_SWTRIG = 6;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_INIT = 1;

  // reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RST = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // request source codes
  localparam logic [SEL_W-1:0] SEL_SOFT = 4'h0;
  localparam logic [SEL_W-1:0] SEL_INT_FALL = 4'h1;
  localparam logic [SEL_W-1:0] SEL_INT_BOTH = 4'h2;
  localparam logic [SEL_W-1:0] SEL_PERIPH_BASE = 4'h3;

  // region holding the controller's own registers
  localparam logic [ADDR_W-1:0] OWN_REG_LO = 20'h00020;
  localparam logic [ADDR_W-1:0] OWN_REG_HI = 20'h0003f;

  // pointer steps per unit
  localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h00001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 20'h00002;

  typedef struct packed {
    logic valid;
    logic we;
    logic byte_unit;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_type;

  localparam mem_req_type MEM_IDLE = '0;

  typedef enum {ST_IDLE, ST_BUS, ST_READ, ST_WRITE, ST_DONE} xfer_state_type;

  function automatic logic in_own_region(input logic [ADDR_W-1:0] a);
    in_own_region = (a >= OWN_REG_LO) && (a <= OWN_REG_HI);
  endfunction

endpackage

/* sim/cycle_steal_dma_controller_bench.sv */
`timescale 1ns/10ps
module cycle_steal_dma_controller_bench;
  import transfer_controller_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, bus_req, bus_gnt, mem_ready, done_irq;
  logic [PERIPH_COUNT-1:0] periph_req = 12'h000;
  logic ext_int = 1'b1;
  logic slow = 1'b0;
  logic was_low = 1'b0;
  mem_req_type mem_req;
  logic [DATA_W-1:0] mem_rdata;
  logic [35:0] rq[$];
  logic [35:0] wq[$];
  logic [31:0] lf = 32'h503d;
  int num_errors = 0;
  int n_checks = 0;
  int irqs = 0;

  always #12.5 clk = ~clk;

  cycle_steal_dma_controller u_cycle_steal_dma_controller (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .periph_req, .ext_int,
    .bus_req, .bus_gnt, .mem_req, .mem_rdata, .mem_ready, .done_irq);
  mem_model u_mem_model (.clk, .slow, .bus_req, .bus_gnt, .mem_req,
    .mem_rdata, .mem_ready);

  function automatic logic [19:0] rnd_addr();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    // bit 16 keeps clear of the own register region
    return 20'h10000 | (lf[19:0] & 20'h0fffe);
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [35:0] e, input logic [35:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t expected %h got %h", $time, e, g);
    end
  endtask

  task automatic tmo(inout int k);
    k++;
    if (k > 400) begin
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      end_sim();
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge clk);
      tmo(k);
    end while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      tmo(k);
    end while (!hreadyout);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back({4'h0, e});
    ahb(1'b0, a, 32'h0);
  endtask

  task automatic setup(input logic [31:0] sel, input logic [19:0] s,
                       input logic [19:0] d, input logic [31:0] rl);
    ahb(1'b1, {24'h0, OFS_SEL}, sel);
    ahb(1'b1, {24'h0, OFS_SRC}, {12'h0, s});
    ahb(1'b1, {24'h0, OFS_DST}, {12'h0, d});
    ahb(1'b1, {24'h0, OFS_RELOAD}, rl);
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h0);
  endtask

  task automatic trig(input int c);
    if (c < 3) begin
      ext_int <= ~ext_int;
    end else begin
      periph_req <= 12'h001 << (c - 3);
      @(posedge clk);
      periph_req <= 12'h000;
    end
  endtask

  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irqs < n || wq.size() != 0 || bus_req) begin
      @(posedge clk);
      tmo(k);
    end
  endtask

  // results are compared in arrival order
  always @(posedge clk) begin
    if (rst_n && was_low && hreadyout)
      chk(rq.size() ? rq.pop_front() : 36'hx, {4'h0, hrdata});
    was_low = !hreadyout;
    if (mem_req.valid && mem_req.we && mem_ready)
      chk(wq.size() ? wq.pop_front() : 36'hx,
          {mem_req.addr, mem_req.wdata});
    if (done_irq)
      irqs++;
  end

  initial begin
    logic [19:0] s, d;
    logic [31:0] cf;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      rd(i == 7 ? 32'h100 : i * 4, 32'h0);
    $display("test reset values done");
    for (int c = 0; c < 15; c++) begin
      s = rnd_addr();
      d = rnd_addr();
      cf = 32'h1 | (c[0] ? 32'h4 : 32'h0) | (c[1] ? 32'h10 : 32'h8);
      slow <= c[2];
      setup(c, s, d, 32'h0);
      wq.push_back({d, c[0] ? {8'h0, s[7:0]} : s[15:0]});
      ahb(1'b1, {24'h0, OFS_CTRL}, cf | (c == 0 ? 32'h40 : 32'h0));
      if (c > 0)
        trig(c);
      wait_irq(irqs + 1);
      rd({24'h0, OFS_CTRL}, cf & ~32'h1);
    end
    $display("test sources done");
    slow <= 1'b0;
    setup(3, s, d, 32'h1);
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h17);
    for (int i = 0; i < 3; i++) begin
      wq.push_back({d + 20'(i), 8'h0, s[7:0]});
      trig(3);
      wait_irq(irqs);
    end
    rd({24'h0, OFS_CTRL}, 32'h17);
    rd({24'h0, OFS_DST}, {12'h0, d + 20'h3});
    ahb(1'b1, {24'h0, OFS_SRC}, 32'h0);
    rd({24'h0, OFS_SRC}, {12'h0, s});
    // three close requests while busy give two units
    wq.push_back({d + 20'h3, 8'h0, s[7:0]});
    wq.push_back({d + 20'h4, 8'h0, s[7:0]});
    for (int i = 0; i < 3; i++) begin
      trig(3);
      @(posedge clk);
    end
    wait_irq(irqs);
    repeat (20) @(posedge clk);
    d = rnd_addr();
    ahb(1'b1, {24'h0, OFS_DST}, {12'h0, d});
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h17);
    wq.push_back({d, 8'h0, s[7:0]});
    trig(3);
    wait_irq(irqs);
    $display("test repeat done");
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h0);
    trig(3);
    repeat (8) @(posedge clk);
    rd({24'h0, OFS_CTRL}, 32'h20);
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h0);
    rd({24'h0, OFS_CTRL}, 32'h0);
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h20);
    rd({24'h0, OFS_CTRL}, 32'h0);
    $display("test request bit done");
    slow <= 1'b1;
    setup(0, 20'h00024, d, 32'h0);
    wq.push_back({d, 16'h0000});
    ahb(1'b1, {24'h0, OFS_CTRL}, 32'h51);
    wait_irq(irqs + 1);
    $display("test own region done");
    end_sim();
  end
endmodule // cycle_steal_dma_controller_bench

/* sim/cycle_steal_dma_controller_props.sv */
`timescale 1ns/10ps
module cycle_steal_dma_controller_props
  import transfer_controller_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // memory side
  input wire logic bus_req,
  input wire logic bus_gnt,
  input wire transfer_controller_pkg::mem_req_type mem_req,
  input wire logic [transfer_controller_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_ready,
  input wire logic done_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  bus_owned_a:
  assert property (mem_req.valid |-> bus_req && bus_gnt)
    else $error("access without bus ownership");
  hold_req_a:
  assert property (mem_req.valid && !mem_ready |=> $stable(mem_req))
    else $error("access changed before ready");
  unit_end_a:
  assert property (mem_req.valid && mem_req.we && mem_ready
    |=> !mem_req.valid ##1 !bus_req)
    else $error("bus not released after unit");
  own_region_a:
  assert property (mem_req.valid |-> mem_req.addr < 20'h00020
    || mem_req.addr > 20'h0003f)
    else $error("own register region accessed");
  byte_upper_a:
  assert property (mem_req.valid && mem_req.we && mem_req.byte_unit
    |-> mem_req.wdata[15:8] == 8'h00)
    else $error("byte unit upper lane not zero");
  copy_data_a:
  assert property (mem_req.valid && !mem_req.we && mem_ready
    && !mem_req.byte_unit
    |=> !mem_req.valid
      || (mem_req.we && mem_req.wdata == $past(mem_rdata)))
    else $error("written word differs from read word");
  irq_pulse_a:
  assert property (done_irq |=> !done_irq)
    else $error("interrupt longer than one cycle");
  irq_at_end_a:
  assert property (done_irq |-> !bus_req && $past(bus_req))
    else $error("interrupt not at unit end");
  read_wait_a:
  assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  okay_resp_a:
  assert property (!hresp)
    else $error("error response given");
endmodule // cycle_steal_dma_controller_props

bind cycle_steal_dma_controller cycle_steal_dma_controller_props u_props (
  .clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .bus_req, .bus_gnt, .mem_req, .mem_rdata, .mem_ready, .done_irq);

/* sim/mem_model.sv */
`timescale 1ns/10ps
module mem_model
  import transfer_controller_pkg::*;
(
  // clock and pace
  input wire logic clk,
  input wire logic slow,
  // bus ownership
  input wire logic bus_req,
  output logic bus_gnt,
  // memory access
  input wire transfer_controller_pkg::mem_req_type mem_req,
  output logic [transfer_controller_pkg::DATA_W-1:0] mem_rdata,
  output logic mem_ready
);
  logic [1:0] wt;
  logic go;

  // slow mode answers only once in four cycles
  assign go = !slow || wt == 2'h3;

  initial begin
    wt = 2'h0;
    bus_gnt = 1'b0;
    mem_ready = 1'b0;
    mem_rdata = 16'h0000;
  end

  always @(posedge clk) begin
    wt <= wt + 2'h1;
    bus_gnt <= bus_req && (bus_gnt || go);
    mem_ready <= mem_req.valid && !mem_ready && go;
    // idle data toggles so stale values never match
    if (mem_req.valid && !mem_req.we && !mem_ready && go) begin
      mem_rdata <= mem_req.addr[15:0];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mem_model

/* src/cycle_steal_dma_controller.sv */
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module cycle_steal_dma_controller
  import transfer_controller_pkg::*;
#(
  parameter int PERIPH_N = transfer_controller_pkg::PERIPH_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // request sources
  input wire logic [PERIPH_N-1:0] periph_req,
  input wire logic ext_int,
  // shared memory bus
  output logic bus_req,
  input wire logic bus_gnt,
  output transfer_controller_pkg::mem_req_type mem_req,
  input wire logic [transfer_controller_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_ready,
  // underflow interrupt request
  output logic done_irq
);
  import transfer_controller_pkg::*;

  // control and configuration
  logic enable;
  logic repeat_mode;
  logic byte_unit;
  logic src_fwd;
  logic dst_fwd;
  logic req_bit;
  logic need_init;
  logic [SEL_W-1:0] source_sel;
  logic [ADDR_W-1:0] src_ptr;
  logic [ADDR_W-1:0] dst_ptr;
  logic [CNT_W-1:0] reload;

  // transfer engine
  xfer_state_type state;
  logic [ADDR_W-1:0] fwd_ptr;
  logic [CNT_W-1:0] cnt;
  logic [ADDR_W-1:0] src_addr;
  logic [ADDR_W-1:0] dst_addr;
  logic start_xfer;
  logic unit_done;
  logic underflow;
  logic req_event;

  // bus slave
  logic wr_pend;
  logic rd_pend;
  logic [7:0] bus_ofs;
  logic bus_mapped;
  logic addr_phase;
  logic [31:0] read_value;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_src;
  logic wr_dst;
  logic wr_reload;
  logic soft_trig;

  function automatic mem_req_type make_req(input logic we,
                                           input logic unit8,
                                           input logic [ADDR_W-1:0] a,
                                           input logic [DATA_W-1:0] d);
    mem_req_type r;
    r.valid = 1'b1;
    r.we = we;
    r.byte_unit = unit8;
    r.addr = a;
    r.wdata = unit8 ? {8'h00, d[7:0]} : d;
    make_req = r;
  endfunction

  // ---------------- register bus slave ----------------

  assign addr_phase = hsel && hready && htrans[1];

  // every access takes the whole word, hsize is not decoded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      bus_ofs <= 8'h00;
      bus_mapped <= 1'b0;
    end else begin
      wr_pend <= addr_phase && hwrite;
      rd_pend <= addr_phase && !hwrite;
      if (addr_phase) begin
        bus_ofs <= haddr[7:0];
        bus_mapped <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
      end
    end
  end

  assign wr_ctrl = wr_pend && bus_mapped && bus_ofs == OFS_CTRL;
  assign wr_sel = wr_pend && bus_mapped && bus_ofs == OFS_SEL;
  assign wr_src = wr_pend && bus_mapped && bus_ofs == OFS_SRC;
  assign wr_dst = wr_pend && bus_mapped && bus_ofs == OFS_DST;
  assign wr_reload = wr_pend && bus_mapped && bus_ofs == OFS_RELOAD;
  assign soft_trig = wr_ctrl && hwdata[CTRL_SWTRIG];

  // reads wait one cycle so a write just before is already visible
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        hreadyout <= 1'b1;
        hrdata <= read_value;
      end
    end
  end

  always_comb begin
    read_value = 32'h00000000;
    if (bus_mapped) begin
      case (bus_ofs)
        OFS_CTRL: begin
          read_value[CTRL_EN] = enable;
          read_value[CTRL_REPEAT] = repeat_mode;
          read_value[CTRL_BYTE] = byte_unit;
          read_value[CTRL_SRC_FWD] = src_fwd;
          read_value[CTRL_DST_FWD] = dst_fwd;
          read_value[CTRL_REQ] = req_bit;
        end
        OFS_SEL: read_value[SEL_W-1:0] = source_sel;
        OFS_SRC: read_value[ADDR_W-1:0] =
          (enable && src_fwd) ? fwd_ptr : src_ptr;
        OFS_DST: read_value[ADDR_W-1:0] =
          (enable && dst_fwd) ? fwd_ptr : dst_ptr;
        OFS_RELOAD: read_value[CNT_W-1:0] = reload;
        OFS_COUNT: read_value[CNT_W-1:0] = cnt;
        OFS_STATUS: begin
          read_value[STAT_BUSY] = state != ST_IDLE;
          read_value[STAT_INIT] = need_init;
        end
        default: read_value = 32'h00000000;
      endcase
    end
  end

  // ---------------- configuration ----------------

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable <= RST_BIT;
      repeat_mode <= RST_BIT;
      byte_unit <= RST_BIT;
      src_fwd <= RST_BIT;
      dst_fwd <= RST_BIT;
      need_init <= RST_BIT;
      source_sel <= SEL_RST;
      reload <= CNT_RST;
    end else begin
      if (underflow && !repeat_mode) begin
        enable <= 1'b0;
      end
      if (start_xfer) begin
        need_init <= 1'b0;
      end
      if (wr_ctrl) begin
        enable <= hwdata[CTRL_EN];
        need_init <= hwdata[CTRL_EN];
        repeat_mode <= hwdata[CTRL_REPEAT];
        byte_unit <= hwdata[CTRL_BYTE];
        src_fwd <= hwdata[CTRL_SRC_FWD];
        dst_fwd <= hwdata[CTRL_DST_FWD];
      end
      if (wr_sel) begin
        source_sel <= hwdata[SEL_W-1:0];
      end
      if (wr_reload) begin
        reload <= hwdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_ptr <= PTR_RST;
      dst_ptr <= PTR_RST;
    end else begin
      if (wr_src && (src_fwd || !enable)) begin
        src_ptr <= hwdata[ADDR_W-1:0];
      end
      if (wr_dst && (dst_fwd || !enable)) begin
        dst_ptr <= hwdata[ADDR_W-1:0];
      end
    end
  end

  // ---------------- request bit ----------------

  request_select #(
    .PERIPH_N(PERIPH_N)
  ) u_request_select (
    .clk(clk),
    .rst_n(rst_n),
    .source_sel(source_sel),
    .soft_trig(soft_trig),
    .periph_req(periph_req),
    .ext_int(ext_int),
    .req_event(req_event)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_bit <= RST_BIT;
    end else if (req_event) begin
      req_bit <= 1'b1;
    end else if (start_xfer) begin
      req_bit <= 1'b0;
    end else if (wr_ctrl && !hwdata[CTRL_REQ]) begin
      req_bit <= 1'b0;
    end
  end

  // ---------------- transfer engine ----------------

  assign start_xfer = (state == ST_IDLE) && enable && req_bit;
  assign unit_done = state == ST_DONE;
  assign underflow = unit_done && (cnt == CNT_RST);

  assign src_addr = src_fwd ? fwd_ptr : src_ptr;
  assign dst_addr = dst_fwd ? fwd_ptr : dst_ptr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bus_req <= 1'b0;
      mem_req <= MEM_IDLE;
      fwd_ptr <= PTR_RST;
      cnt <= CNT_RST;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_xfer) begin
            if (need_init) begin
              fwd_ptr <= src_fwd ? src_ptr : dst_ptr;
              cnt <= reload;
            end
            bus_req <= 1'b1;
            state <= ST_BUS;
          end
        end
        ST_BUS: begin
          if (bus_gnt) begin
            if (in_own_region(src_addr)) begin
              if (in_own_region(dst_addr)) begin
                state <= ST_DONE;
              end else begin
                mem_req <= make_req(1'b1, byte_unit, dst_addr, DATA_RST);
                state <= ST_WRITE;
              end
            end else begin
              mem_req <= make_req(1'b0, byte_unit, src_addr, DATA_RST);
              state <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (mem_ready) begin
            if (in_own_region(dst_addr)) begin
              mem_req <= MEM_IDLE;
              state <= ST_DONE;
            end else begin
              mem_req <= make_req(1'b1, byte_unit, dst_addr, mem_rdata);
              state <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (mem_ready) begin
            mem_req <= MEM_IDLE;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          bus_req <= 1'b0;
          if (src_fwd || dst_fwd) begin
            fwd_ptr <= fwd_ptr + (byte_unit ? STEP_BYTE : STEP_WORD);
          end
          // reload plus one units per run
          if (cnt == CNT_RST) begin
            cnt <= repeat_mode ? reload : CNT_RST;
          end else begin
            cnt <= cnt - 16'h0001;
          end
          state <= ST_IDLE;
        end
        default: begin
          bus_req <= 1'b0;
          mem_req <= MEM_IDLE;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // no mask or priority input reaches the engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_irq <= 1'b0;
    end else begin
      done_irq <= underflow;
    end
  end

endmodule // cycle_steal_dma_controller

/* src/request_select.sv */
`timescale 1ns/10ps
module request_select
  import transfer_controller_pkg::*;
#(
  parameter int PERIPH_N = transfer_controller_pkg::PERIPH_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selection and software trigger
  input wire logic [transfer_controller_pkg::SEL_W-1:0] source_sel,
  input wire logic soft_trig,
  // request inputs
  input wire logic [PERIPH_N-1:0] periph_req,
  input wire logic ext_int,
  // merged request pulse
  output logic req_event
);
  import transfer_controller_pkg::*;

  logic ext_prev;
  logic periph_hit;
  logic [SEL_W-1:0] periph_idx;

  // pin idles high, so no false falling edge after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_prev <= 1'b1;
    end else begin
      ext_prev <= ext_int;
    end
  end

  always_comb begin
    periph_idx = source_sel - SEL_PERIPH_BASE;
    periph_hit = 1'b0;
    if (source_sel >= SEL_PERIPH_BASE && periph_idx < PERIPH_N) begin
      periph_hit = periph_req[periph_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_event <= 1'b0;
    end else begin
      case (source_sel)
        SEL_SOFT: req_event <= soft_trig;
        SEL_INT_FALL: req_event <= ext_prev & ~ext_int;
        SEL_INT_BOTH: req_event <= ext_prev ^ ext_int;
        default: req_event <= periph_hit;
      endcase
    end
  end

endmodule // request_select
